// file: core/smf_regs.vh
// register layout, op-codes and timing of the serial status front end
`ifndef SMF_REGS_VH
`define SMF_REGS_VH
`define SMF_BIT_SPARE_NV 7
`define SMF_BIT_SPARE_HI 6
`define SMF_BIT_SPARE_LO 4
`define SMF_BIT_PROT_HI 3
`define SMF_BIT_PROT_LO 2
`define SMF_BIT_LATCH 1
`define SMF_BIT_BUSY 0
`define SMF_STATUS_RESET 8'h00
`define SMF_OP_LATCH_SET 8'h06
`define SMF_OP_LATCH_CLR 8'h04
`define SMF_OP_STAT_READ 8'h05
`define SMF_OP_STAT_WRITE 8'h01
`define SMF_OP_WRITE 8'h02
`define SMF_NV_WRITE_NS 2000
`define SMF_CLK_NS 40
`define SMF_NV_WRITE_CYC 16'd50
`endif

// file: core/smf_sync.v
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module smf_sync (
  input wire clk,
  input wire rst,
  input wire d,
  output reg q
);
  reg s1;
  reg s2;
  reg s3;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      q <= 1'b0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      // change counts only once second and third agree
      if (s2 == s3)
        q <= s3;
    end
  end
endmodule
`default_nettype wire

// file: core/smf_frontend.v
// serial memory interface front end with status register
`timescale 1ns/1ps
`default_nettype none
`include "smf_regs.vh"
// Behaviour
// [R01] select high: standby, output released, inputs ignored
// [R02] select low activates; master lowers before op-code
// [R03] input sampled on serial clock rising edge
// [R04] output changes on serial clock falling edge
// [R05] modes 0 and 3 both supported
// [R06] slave only, own select on shared bus
// [R07] bit 7 spare nonvolatile, writable, starts 0
// [R08] bits 6..4 spare volatile, writable, start 000
// [R09] bits 3..2 protect size, writable, readable
// [R10] bit 1 enable latch: set/cleared by commands
// [R11] latch cleared: power-on, disable, write completion
// [R12] bit 0 busy; only status read while busy
// [R13] commands in on input; read data out
// [R14] enable 06, disable 04, msb first
// [R15] status read 05 repeats every eight clocks
// [R16] status write 01 plus byte, busy after deselect
// [R17] status write leaves bits 1 and 0 alone
// [R18] deselect resets bit counter and decoder
module smf_frontend (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire sck,
  input wire si,
  output reg so,
  output reg so_oe,
  output reg [7:0] status_flags,
  output reg mem_write_req
);
  localparam ST_OP = 2'd0;
  localparam ST_DATA = 2'd1;
  localparam ST_READ = 2'd2;
  localparam ST_SKIP = 2'd3;
  // select synced active high, so reset reads as deselected
  wire sel_s;
  wire sck_s;
  wire si_s;
  reg sck_d;
  reg sel_d;
  reg [1:0] state;
  reg [2:0] bit_cnt;
  reg [7:0] shreg;
  reg [7:0] wr_data;
  reg wr_pend;
  reg mem_pend;
  reg dis_pend;
  reg [15:0] wip_cnt;
  reg [7:0] out_byte;
  // op-code compare, shared by all five op-code decodes
  function op_is;
    input [7:0] code;
    input [7:0] op;
    begin
      op_is = (code == op);
    end
  endfunction
  // edges seen through the sync delay, four to five clocks
  wire rise = sck_s & ~sck_d; // R05
  wire fall = ~sck_s & sck_d;
  wire selected = sel_s; // R02
  wire cs_rise = ~sel_s & sel_d;
  wire [7:0] next_shreg = {shreg[6:0], si_s};
  wire byte_done = selected & rise & (bit_cnt == 3'd7);
  wire busy = status_flags[`SMF_BIT_BUSY];
  wire latch = status_flags[`SMF_BIT_LATCH];
  wire op_read = op_is(next_shreg, `SMF_OP_STAT_READ); // R15
  wire op_set = op_is(next_shreg, `SMF_OP_LATCH_SET); // R14
  wire op_clr = op_is(next_shreg, `SMF_OP_LATCH_CLR); // R14
  wire op_swr = op_is(next_shreg, `SMF_OP_STAT_WRITE); // R16
  wire op_mwr = op_is(next_shreg, `SMF_OP_WRITE);
  // latch sets at the eighth bit, not at deselect
  wire latch_set = byte_done & (state == ST_OP) & op_set & ~busy;
  // write timer starts only at the select rising edge
  wire start_write = cs_rise & (wr_pend | mem_pend);
  wire wip_done = (wip_cnt == 16'd1);
  // slave only: select, clock and data are all inputs
  smf_sync u_cs (.clk(clk), .rst(rst), .d(~cs_n), .q(sel_s)); // R06
  smf_sync u_sck (.clk(clk), .rst(rst), .d(sck), .q(sck_s));
  smf_sync u_si (.clk(clk), .rst(rst), .d(si), .q(si_s));
  // edge history of the synced pins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_d <= 1'b0;
      sel_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
      sel_d <= sel_s;
    end
  end
  // bit counter restarts with every select
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= 3'd0;
      shreg <= 8'h00;
    end else if (!selected) begin
      bit_cnt <= 3'd0; // R18
    end else if (rise) begin // R03
      bit_cnt <= bit_cnt + 3'd1;
      shreg <= next_shreg; // R13
    end
  end
  // command decoder
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ST_OP;
      out_byte <= 8'h00;
      wr_data <= 8'h00;
      wr_pend <= 1'b0;
      mem_pend <= 1'b0;
      dis_pend <= 1'b0;
    end else if (!selected) begin
      state <= ST_OP; // R18 R01
      if (cs_rise) begin
        wr_pend <= 1'b0;
        mem_pend <= 1'b0;
        dis_pend <= 1'b0;
      end
    end else if (byte_done) begin
      case (state)
        ST_OP: begin
          state <= ST_SKIP;
          if (op_read) begin // R15 R12
            state <= ST_READ;
            out_byte <= status_flags;
          end else if (busy) begin
            // busy: anything but status read is dropped
            state <= ST_SKIP; // R12
          end else if (op_clr) begin
            dis_pend <= 1'b1; // R11
          end else if (op_swr) begin
            state <= ST_DATA; // R16
          end else if (op_mwr) begin
            // no array here: only the busy time is modelled
            mem_pend <= latch;
          end
        end
        ST_DATA: begin
          // write ignored unless latch set
          if (latch) begin // R10
            wr_data <= next_shreg;
            wr_pend <= 1'b1;
          end
          state <= ST_SKIP;
        end
        ST_READ: begin
          // resampled so polling sees the busy bit drop
          out_byte <= status_flags; // R15
        end
        ST_SKIP: begin
          state <= ST_SKIP;
        end
        default: begin
          state <= ST_SKIP;
        end
      endcase
    end
  end
  // internal write timer, runs regardless of select
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wip_cnt <= 16'd0;
    end else if (start_write) begin
      wip_cnt <= `SMF_NV_WRITE_CYC;
    end else if (wip_cnt != 16'd0) begin
      wip_cnt <= wip_cnt - 16'd1;
    end
  end
  // status register
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_flags <= `SMF_STATUS_RESET; // R07 R08 R11
    end else begin
      if (cs_rise && wr_pend) begin
        // bits 1 and 0 keep their value
        status_flags[`SMF_BIT_SPARE_NV:`SMF_BIT_PROT_LO] <=
          wr_data[`SMF_BIT_SPARE_NV:`SMF_BIT_PROT_LO]; // R17 R07 R08 R09
      end
      if (wip_done) begin
        status_flags[`SMF_BIT_BUSY] <= 1'b0; // R12
      end
      if (start_write) begin
        status_flags[`SMF_BIT_BUSY] <= 1'b1; // R16
      end
      if (wip_done || (cs_rise && dis_pend)) begin
        status_flags[`SMF_BIT_LATCH] <= 1'b0; // R11
      end
      // a set in the same cycle as a clear wins
      if (latch_set) begin
        status_flags[`SMF_BIT_LATCH] <= 1'b1; // R10
      end
    end
  end
  // array write strobe at deselect
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      mem_write_req <= 1'b0;
    end else begin
      mem_write_req <= cs_rise & mem_pend;
    end
  end
  // serial output: released whenever deselected
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (!selected) begin
      // so low while released: no high impedance inside
      so_oe <= 1'b0; // R01
      so <= 1'b0;
    end else if (fall && state == ST_READ) begin // R04 R13
      so_oe <= 1'b1;
      so <= out_byte[3'd7 - bit_cnt];
    end
  end
endmodule
`default_nettype wire

// file: sim/smf_checker.sv
// port checker for the front end
`timescale 1ns/1ps
`default_nettype none
module smf_checker (
  input wire clk,
  input wire rst,
  input wire cs_n,
  input wire so,
  input wire so_oe,
  input wire [7:0] status_flags,
  input wire mem_write_req);
  wire busy = status_flags[0];
  wire latch = status_flags[1];
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  oe_idle_a: assert property (cs_n [*8] |-> !so_oe) else $error("oe");
  so_rel_a: assert property (!so_oe |-> !so) else $error("so");
  busy_len_a: assert property ($rose(busy) |-> cs_n ##0 busy [*8])
    else $error("len");
  busy_end_a: assert property ($fell(busy) |-> !latch)
    else $error("end");
  nv_hold_a: assert property (busy && $past(busy, 2)
    |-> $stable(status_flags[7:2])) else $error("hold");
  nv_upd_a: assert property ($changed(status_flags[7:2]) |-> cs_n)
    else $error("upd");
  latch_set_a: assert property ($rose(latch) |-> !busy)
    else $error("set");
  latch_clr_a: assert property ($fell(latch) |-> cs_n || $fell(busy))
    else $error("clr");
  mem_req_a: assert property (mem_write_req |-> busy)
    else $error("req");
  cover property ($rose(busy));
  cover property (mem_write_req);
  cover property ($fell(latch));
  cover property ($rose(so_oe));
endmodule
bind smf_frontend smf_checker chk (.clk, .rst, .cs_n, .so, .so_oe,
  .status_flags, .mem_write_req);
`default_nettype wire

// file: sim/smf_spi_master.sv
// serial master model
`timescale 1ns/1ps
`default_nettype none
module smf_spi_master (
  output logic cs_n,
  output logic sck,
  output logic si,
  input wire logic so);
  logic cpol = 1'b0; // mode 3 when set
  initial {cs_n, sck, si} = 3'b100;
  task automatic frame(input logic [7:0] op, d, input int n,
    output logic [7:0] q);
    sck = cpol;
    #60 cs_n = 1'b0;
    #300;
    for (int i = 8 * n + 7; i >= 0; i--) begin
      sck = 1'b0;
      si = i < 8 * n ? d[i % 8] : op[i % 8];
      #160 sck = 1'b1;
      #160 q[i % 8] = so; // late sample: slow output
      sck = cpol;
    end
    #300 cs_n = 1'b1;
    si = ~si; // no stale level
  endtask
endmodule
`default_nettype wire

// file: sim/smf_frontend_tb_top.sv
// front end bench
`timescale 1ns/1ps
`default_nettype none
module smf_frontend_tb_top;
  logic clk = 1'b0, rst = 1'b1;
  logic [7:0] q;
  int n_errors = 0, checks = 0;
  wire cs_n, sck, si, so, so_oe;
  wire [7:0] status_flags;
  always #20 clk = ~clk;
  smf_frontend uut (.clk, .rst, .cs_n, .sck, .si, .so, .so_oe,
    .status_flags, .mem_write_req());
  smf_spi_master m (.cs_n, .sck, .si, .so(so_oe ? so : 1'bz));
  task automatic chk(input string s, input logic [7:0] got, exp);
    checks++;
    n_errors += int'(got !== exp);
    if (got !== exp) $display("ERROR %s exp %h got %h", s, exp, got);
  endtask
  task automatic conclude();
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic run(input logic [7:0] op, d, e, input int n);
    m.frame(op, d, n, q);
    if (op == 8'h05) chk("read", q, e);
    #600 chk("status", status_flags, e);
  endtask
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    chk("reset", status_flags, 8'h00);
    run(8'h05, 8'h00, 8'h00, 2);
    run(8'h06, 8'h00, 8'h02, 0);
    run(8'h01, 8'ha9, 8'hab, 1);
    run(8'h05, 8'h00, 8'ha8, 2);
    run(8'h01, 8'h00, 8'ha8, 1);
    run(8'h06, 8'h00, 8'haa, 0);
    run(8'h02, 8'h00, 8'hab, 0);
    run(8'h04, 8'h00, 8'ha8, 0);
    m.cpol = 1'b1;
    run(8'h05, 8'h00, 8'ha8, 2);
    conclude();
  end
endmodule
`default_nettype wire
